// *** design/aos_core.sv ***
// Four guarded accumulators with overflow flags and saturation modes.
// Assumes core-issued operations and an Avalon-MM master on one clock.
//
// Functional notes
// - Four accumulators, each with eight guard bits above 32 result bits.
// - Guard bits absorb 256 back-to-back MAC results before overflow.
// - Each accumulator owns a flag, set when its operation overflows.
// - Data-unit saturate enable set: overflowing result written clamped.
// - Accumulator flag sets on data-unit overflow, saturation on or off.
// - Address unit keeps no flags; it clamps overflow when enabled.
// - Clamp goes to nearest limit: address unit 7FFFh above and 8000h below, data unit 7F_FFFF_FFFFh and 80_0000_0000h.
`default_nettype none
module aos_core (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [aos_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [aos_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [aos_pkg::BE_W-1:0] avs_byteenable,
    output logic [aos_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic d_op_valid,
    input wire aos_pkg::aos_dop_t d_op_code,
    input wire logic [aos_pkg::IDX_W-1:0] d_op_acc,
    input wire logic [aos_pkg::RES_W-1:0] d_op_data,
    input wire logic [aos_pkg::MUL_W-1:0] d_op_mul_x,
    input wire logic [aos_pkg::MUL_W-1:0] d_op_mul_y,
    input wire logic a_op_valid,
    input wire logic a_op_sub,
    input wire logic [aos_pkg::A_W-1:0] a_op_x,
    input wire logic [aos_pkg::A_W-1:0] a_op_y,
    output logic [aos_pkg::A_W-1:0] a_result,
    output logic a_result_valid,
    output logic [aos_pkg::ACC_W-1:0] accumulator_0,
    output logic [aos_pkg::ACC_W-1:0] accumulator_1,
    output logic [aos_pkg::ACC_W-1:0] accumulator_2,
    output logic [aos_pkg::ACC_W-1:0] accumulator_3,
    output logic [aos_pkg::ACC_N-1:0] ovf_flags,
    output logic data_unit_saturate_enable,
    output logic address_unit_saturate_enable
);
    import aos_pkg::*;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic acc_hit(input logic [ADDR_W-1:0] addr,
                                     input int idx, input logic hi);
        logic [ADDR_W-1:0] base;
        base = OFS_ACC_BASE + ADDR_W'(idx) * ACC_STRIDE;
        acc_hit = (addr == (hi ? base + HI_OFS : base));
    endfunction

    function automatic logic fits_res(input logic [ACC_W-1:0] v);
        fits_res = (v[ACC_W-1:RES_W-1] == {(GUARD_W+1){v[RES_W-1]}});
    endfunction

    // ****************************************
    // Bus handshake
    // ****************************************
    logic ack_reg;
    logic ack_next;
    logic bus_req;
    logic bus_wr;
    logic rd_take;
    logic ctrl_wr;
    logic ovf_wr;

    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~(ack_reg & ce);
    assign bus_wr = avs_write & ack_reg & ce;
    assign rd_take = avs_read & ~ack_reg & ce;
    assign ctrl_wr = bus_wr & avs_byteenable[BE_LOW] &
                     (avs_address == OFS_CTRL);
    assign ovf_wr = bus_wr & avs_byteenable[BE_LOW] &
                    (avs_address == OFS_OVF);

    always_comb begin
        ack_next = bus_req & ~ack_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_reg <= 1'h0;
        end else if (ce) begin
            ack_reg <= ack_next;
        end
    end

    // ****************************************
    // Saturation mode control
    // ****************************************
    logic data_unit_saturate_enable_reg;
    logic data_unit_saturate_enable_next;
    logic address_unit_saturate_enable_reg;
    logic address_unit_saturate_enable_next;

    always_comb begin
        data_unit_saturate_enable_next = data_unit_saturate_enable_reg;
        address_unit_saturate_enable_next = address_unit_saturate_enable_reg;
        if (ctrl_wr) begin
            data_unit_saturate_enable_next = avs_writedata[BIT_DATA_UNIT_SATURATE_ENABLE];
            address_unit_saturate_enable_next = avs_writedata[BIT_ADDRESS_UNIT_SATURATE_ENABLE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_unit_saturate_enable_reg <= CTRL_RST;
            address_unit_saturate_enable_reg <= CTRL_RST;
        end else if (ce) begin
            data_unit_saturate_enable_reg <= data_unit_saturate_enable_next;
            address_unit_saturate_enable_reg <= address_unit_saturate_enable_next;
        end
    end

    assign data_unit_saturate_enable = data_unit_saturate_enable_reg;
    assign address_unit_saturate_enable = address_unit_saturate_enable_reg;

    // ****************************************
    // Data unit
    // ****************************************
    logic [ACC_W-1:0] acc_reg [ACC_N];
    logic [ACC_W-1:0] d_acc_old;
    logic [ACC_W-1:0] d_result;
    logic d_ovf;
    logic d_fire;

    assign d_fire = ce & d_op_valid;
    assign d_acc_old = acc_reg[d_op_acc];

    aos_d_alu u_d_alu (
        .acc_in(d_acc_old),
        .op(d_op_code),
        .operand(d_op_data),
        .mul_x(d_op_mul_x),
        .mul_y(d_op_mul_y),
        .sat_en(data_unit_saturate_enable_reg),
        .result(d_result),
        .overflow(d_ovf)
    );

    // ****************************************
    // Accumulators and overflow flags
    // ****************************************
    logic [ACC_N-1:0] ovf_reg;
    logic [ACC_N-1:0] ovf_clr;
    logic [ACC_N-1:0] ovf_keep;

    assign ovf_clr = ovf_wr ? avs_writedata[ACC_N-1:0] : OVF_RST;
    assign ovf_keep = ovf_reg & ~ovf_clr;

    genvar gi;
    generate
        for (gi = 0; gi < ACC_N; gi++) begin : g_acc
            logic [ACC_W-1:0] acc_next;
            logic ovf_next;
            logic hit;
            assign hit = d_fire & (d_op_acc == IDX_W'(gi));
            always_comb begin
                acc_next = hit ? d_result : acc_reg[gi];
                // Set wins over a same-cycle clear
                ovf_next = ovf_keep[gi] |
                           (hit & d_ovf);
            end
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    acc_reg[gi] <= ACC_RST;
                    ovf_reg[gi] <= 1'h0;
                end else if (ce) begin
                    acc_reg[gi] <= acc_next;
                    ovf_reg[gi] <= ovf_next;
                end
            end
        end
    endgenerate

    assign accumulator_0 = acc_reg[0];
    assign accumulator_1 = acc_reg[1];
    assign accumulator_2 = acc_reg[2];
    assign accumulator_3 = acc_reg[3];
    assign ovf_flags = ovf_reg;

    // ****************************************
    // Address unit
    // ****************************************
    logic [A_W-1:0] a_sum;
    logic a_ovf;
    logic a_fire;
    logic [A_W-1:0] a_res_reg;
    logic [A_W-1:0] a_res_next;
    logic a_val_reg;
    logic a_val_next;

    assign a_fire = ce & a_op_valid;

    aos_a_alu u_a_alu (
        .x(a_op_x),
        .y(a_op_y),
        .sub(a_op_sub),
        .sat_en(address_unit_saturate_enable_reg),
        .result(a_sum),
        .overflow(a_ovf)
    );

    always_comb begin
        a_res_next = a_op_valid ? a_sum : a_res_reg;
        a_val_next = a_op_valid;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            a_res_reg <= A_RST;
            a_val_reg <= 1'h0;
        end else if (ce) begin
            a_res_reg <= a_res_next;
            a_val_reg <= a_val_next;
        end
    end

    assign a_result = a_res_reg;
    assign a_result_valid = a_val_reg;

    // ****************************************
    // Read data
    // ****************************************
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        rd_mux = RD_ZERO;
        if (avs_address == OFS_CTRL) begin
            rd_mux[BIT_DATA_UNIT_SATURATE_ENABLE] = data_unit_saturate_enable_reg;
            rd_mux[BIT_ADDRESS_UNIT_SATURATE_ENABLE] = address_unit_saturate_enable_reg;
        end else if (avs_address == OFS_OVF) begin
            rd_mux[ACC_N-1:0] = ovf_reg;
        end
        for (int i = 0; i < ACC_N; i++) begin
            if (acc_hit(avs_address, i, 1'h0)) begin
                rd_mux = acc_reg[i][RES_W-1:0];
            end
            if (acc_hit(avs_address, i, 1'h1)) begin
                rd_mux[GUARD_W-1:0] = acc_reg[i][ACC_W-1:RES_W];
            end
        end
        rdata_next = rd_take ? rd_mux : rdata_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg <= RD_ZERO;
        end else if (ce) begin
            rdata_reg <= rdata_next;
        end
    end

    assign avs_readdata = rdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence d_ovf_s;
        d_fire && d_ovf;
    endsequence

    sequence a_ovf_s;
        a_fire && a_ovf;
    endsequence

    acc_guard_a: assert property (
        d_fire && d_op_code == D_LOAD |=>
        fits_res(acc_reg[$past(d_op_acc)]))
        else $error("load did not sign-fill the guard bits");

    mac_headroom_a: assert property (
        d_fire && d_op_code == D_MAC && fits_res(d_acc_old) |-> !d_ovf)
        else $error("MAC overflowed inside guard headroom");

    flag_set_a: assert property (
        d_ovf_s |=> ovf_reg[$past(d_op_acc)])
        else $error("overflow flag not set");

    sat_write_a: assert property (
        d_ovf_s ##0 data_unit_saturate_enable_reg |=> acc_reg[$past(d_op_acc)] ==
        ($past(d_acc_old[ACC_W-1]) ? ACC_MIN : ACC_MAX))
        else $error("data unit did not clamp");

    wrap_flag_a: assert property (
        d_ovf_s ##0 !data_unit_saturate_enable_reg |=> ovf_reg[$past(d_op_acc)] &&
        acc_reg[$past(d_op_acc)][ACC_W-1] != $past(d_acc_old[ACC_W-1]))
        else $error("wrapped overflow lost flag or value");

    a_no_flag_a: assert property (
        a_fire && !d_fire && !ovf_wr |=> $stable(ovf_reg))
        else $error("address unit touched a flag");

    a_wrap_a: assert property (
        a_ovf_s ##0 !address_unit_saturate_enable_reg |=> a_res_reg[A_W-1] != $past(a_op_x[A_W-1]))
        else $error("address unit clamped while disabled");

    a_sat_pos_a: assert property (
        a_ovf_s ##0 address_unit_saturate_enable_reg && !a_op_x[A_W-1] |=> a_res_reg == A_MAX)
        else $error("positive clamp not 7FFF");

    a_sat_neg_a: assert property (
        a_ovf_s ##0 address_unit_saturate_enable_reg && a_op_x[A_W-1] |=> a_res_reg == A_MIN)
        else $error("negative clamp not 8000");

    flag_sticky_a: assert property (
        1'h1 |=> (ovf_reg & $past(ovf_keep)) == $past(ovf_keep))
        else $error("overflow flag dropped without clear");

endmodule
`default_nettype wire

// *** design/aos_pkg.sv ***
// Constants and types for the accumulator overflow and saturation block.
// Assumes one core clock; shared by the core and both arithmetic units.
`default_nettype none
package aos_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ACC_N = 4;
    localparam int MAC_HEADROOM = 256;
    localparam int GUARD_W = $clog2(MAC_HEADROOM);
    localparam int RES_W = 32;
    localparam int ACC_W = RES_W + GUARD_W;
    localparam int A_W = 16;
    localparam int MUL_W = 16;
    localparam int IDX_W = 2;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // ****************************************
    // Limits and reset values
    // ****************************************
    localparam logic [ACC_W-1:0] ACC_MAX = 40'h7F_FFFF_FFFF;
    localparam logic [ACC_W-1:0] ACC_MIN = 40'h80_0000_0000;
    localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [A_W-1:0] A_MAX = 16'h7FFF;
    localparam logic [A_W-1:0] A_MIN = 16'h8000;
    localparam logic [A_W-1:0] A_RST = 16'h0000;
    localparam logic [ACC_N-1:0] OVF_RST = 4'h0;
    localparam logic CTRL_RST = 1'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_OVF = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_ACC_BASE = 6'h10;
    localparam logic [ADDR_W-1:0] ACC_STRIDE = 6'h08;
    localparam logic [ADDR_W-1:0] HI_OFS = 6'h04;
    localparam int BIT_DATA_UNIT_SATURATE_ENABLE = 0;
    localparam int BIT_ADDRESS_UNIT_SATURATE_ENABLE = 1;
    localparam int BE_LOW = 0;

    typedef enum logic [1:0] {D_LOAD, D_ADD, D_SUB, D_MAC} aos_dop_t;

endpackage
`default_nettype wire

// *** design/aos_d_alu.sv ***
// Data-unit arithmetic on one 40-bit accumulator, with overflow and clamp.
// Assumes the caller registers the result; purely combinational.
`default_nettype none
module aos_d_alu (
    input wire logic [aos_pkg::ACC_W-1:0] acc_in,
    input wire aos_pkg::aos_dop_t op,
    input wire logic [aos_pkg::RES_W-1:0] operand,
    input wire logic [aos_pkg::MUL_W-1:0] mul_x,
    input wire logic [aos_pkg::MUL_W-1:0] mul_y,
    input wire logic sat_en,
    output logic [aos_pkg::ACC_W-1:0] result,
    output logic overflow
);
    import aos_pkg::*;

    logic signed [ACC_W:0] ext_acc;
    logic signed [ACC_W:0] ext_opd;
    logic signed [ACC_W:0] wide;
    logic signed [2*MUL_W-1:0] prod;

    // ****************************************
    // Sum one bit wider than the accumulator
    // ****************************************
    always_comb begin
        prod = $signed(mul_x) * $signed(mul_y);
        ext_acc = {acc_in[ACC_W-1], acc_in};
        ext_opd = (ACC_W+1)'($signed(operand));
        case (op)
            D_LOAD: wide = ext_opd;
            D_ADD: wide = ext_acc + ext_opd;
            D_SUB: wide = ext_acc - ext_opd;
            D_MAC: wide = ext_acc + (ACC_W+1)'(prod);
            default: wide = ext_acc;
        endcase
        overflow = wide[ACC_W] ^ wide[ACC_W-1];
        if (overflow && sat_en) begin
            result = wide[ACC_W] ? ACC_MIN : ACC_MAX;
        end else begin
            result = wide[ACC_W-1:0];
        end
    end

endmodule
`default_nettype wire

// *** design/aos_a_alu.sv ***
// Address-unit 16-bit add or subtract with optional clamp, no flag kept.
// Assumes the caller registers the result; purely combinational.
`default_nettype none
module aos_a_alu (
    input wire logic [aos_pkg::A_W-1:0] x,
    input wire logic [aos_pkg::A_W-1:0] y,
    input wire logic sub,
    input wire logic sat_en,
    output logic [aos_pkg::A_W-1:0] result,
    output logic overflow
);
    import aos_pkg::*;

    logic signed [A_W:0] wide;

    // ****************************************
    // Sum and clamp
    // ****************************************
    always_comb begin
        if (sub) begin
            wide = $signed({x[A_W-1], x}) - $signed({y[A_W-1], y});
        end else begin
            wide = $signed({x[A_W-1], x}) + $signed({y[A_W-1], y});
        end
        overflow = wide[A_W] ^ wide[A_W-1];
        if (overflow && sat_en) begin
            result = wide[A_W] ? A_MIN : A_MAX;
        end else begin
            result = wide[A_W-1:0];
        end
    end

endmodule
`default_nettype wire

// *** test/accumulator_overflow_saturation_tb.sv ***
// Self-checking bench for the accumulator overflow and saturation core.
// Assumes aos_pkg and aos_core compiled first; one 125 MHz clock.
`default_nettype none
module accumulator_overflow_saturation_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aos_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    typedef struct packed {
        logic unit;
        logic sat;
        aos_dop_t op;
        logic [1:0] idx;
        logic [31:0] data;
        logic [15:0] x;
        logic [15:0] y;
        logic [39:0] ev;
    } aos_row_t;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic d_op_valid = 1'h0;
    aos_dop_t d_op_code = D_LOAD;
    logic [1:0] d_op_acc = 2'h0;
    logic [31:0] d_op_data = 32'h0;
    logic [15:0] d_op_mul_x = 16'h0;
    logic [15:0] d_op_mul_y = 16'h0;
    logic a_op_valid = 1'h0;
    logic a_op_sub = 1'h0;
    logic [15:0] a_op_x = 16'h0;
    logic [15:0] a_op_y = 16'h0;
    logic [15:0] a_result;
    logic a_result_valid;
    logic [39:0] acc0, acc1, acc2, acc3;
    logic [3:0] ovf_flags;
    logic sat_d, sat_a;
    logic [31:0] rd;
    int n_errors = 0;
    int total_checks = 0;
    aos_row_t rows [10] = '{
        '{1'h1, 1'h1, D_ADD, 2'h0, 32'h0, 16'h7FFF, 16'h0001, 40'h7FFF},
        '{1'h1, 1'h0, D_ADD, 2'h0, 32'h0, 16'h7FFF, 16'h0001, 40'h8000},
        '{1'h1, 1'h1, D_SUB, 2'h0, 32'h0, 16'h8000, 16'h0001, 40'h8000},
        '{1'h1, 1'h1, D_ADD, 2'h0, 32'h0, 16'h1234, 16'h0001, 40'h1235},
        '{1'h1, 1'h1, D_ADD, 2'h0, 32'h0, 16'h8000, 16'hFFFF, 40'h8000},
        '{1'h0, 1'h0, D_LOAD, 2'h3, 32'h8000_0000, 16'h0, 16'h0,
          40'hFF_8000_0000},
        '{1'h0, 1'h0, D_SUB, 2'h3, 32'h1, 16'h0, 16'h0, 40'hFF_7FFF_FFFF},
        '{1'h0, 1'h0, D_ADD, 2'h2, 32'h7FFF_FFFF, 16'h0, 16'h0,
          40'h00_7FFF_FFFF},
        '{1'h0, 1'h0, D_MAC, 2'h1, 32'h0, 16'h8000, 16'h8000,
          40'h00_4000_0000},
        '{1'h0, 1'h0, D_MAC, 2'h1, 32'h0, 16'h7FFF, 16'h8000,
          40'h00_0000_8000}
    };

    aos_core dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .d_op_valid(d_op_valid),
        .d_op_code(d_op_code), .d_op_acc(d_op_acc), .d_op_data(d_op_data),
        .d_op_mul_x(d_op_mul_x), .d_op_mul_y(d_op_mul_y),
        .a_op_valid(a_op_valid), .a_op_sub(a_op_sub), .a_op_x(a_op_x),
        .a_op_y(a_op_y), .a_result(a_result),
        .a_result_valid(a_result_valid), .accumulator_0(acc0),
        .accumulator_1(acc1), .accumulator_2(acc2), .accumulator_3(acc3),
        .ovf_flags(ovf_flags), .data_unit_saturate_enable(sat_d),
        .address_unit_saturate_enable(sat_a)
    );

    always #4 ref_clk = ~ref_clk;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [39:0] e,
                       input logic [39:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'h0 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        chk("bus_wait", 40'h0, {39'h0, avs_waitrequest});
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(negedge ref_clk);
    endtask

    task automatic op_go(input aos_row_t r, input int n);
        @(posedge ref_clk);
        d_op_code <= r.op;
        d_op_acc <= r.idx;
        d_op_data <= r.data;
        d_op_mul_x <= r.x;
        d_op_mul_y <= r.y;
        a_op_sub <= (r.op == D_SUB);
        a_op_x <= r.x;
        a_op_y <= r.y;
        d_op_valid <= !r.unit;
        a_op_valid <= r.unit;
        repeat (n) @(posedge ref_clk);
        d_op_valid <= 1'h0;
        a_op_valid <= 1'h0;
        @(negedge ref_clk);
    endtask

    task automatic mac(input logic [1:0] i, input logic [15:0] x,
                       input logic [15:0] y, input int n);
        op_go('{1'h0, 1'h0, D_MAC, i, 32'h0, x, y, 40'h0}, n);
    endtask

    task automatic ld(input logic [1:0] i, input logic [31:0] d);
        op_go('{1'h0, 1'h0, D_LOAD, i, d, 16'h0, 16'h0, 40'h0}, 1);
    endtask

    function automatic logic [39:0] acc_of(input logic [1:0] i);
        case (i)
            2'h0: return acc0;
            2'h1: return acc1;
            2'h2: return acc2;
            default: return acc3;
        endcase
    endfunction

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge ref_clk);
        $display("[FAIL] watchdog expected done seen hang");
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(negedge ref_clk);
        chk("acc_rst", 40'h0, acc0 | acc1 | acc2 | acc3);
        chk("flags_rst", 40'h0, {36'h0, ovf_flags});
        chk("modes_rst", 40'h0, {38'h0, sat_a, sat_d});
        foreach (rows[i]) begin
            bus(1'h1, OFS_CTRL, {30'h0, rows[i].sat, rows[i].sat}, 4'hF);
            bus(1'h1, OFS_OVF, 32'hF, 4'hF);
            op_go(rows[i], 1);
            if (rows[i].unit) begin
                chk("a_result", rows[i].ev, {24'h0, a_result});
                chk("a_valid", 40'h1, {39'h0, a_result_valid});
            end else begin
                chk("acc", rows[i].ev, acc_of(rows[i].idx));
            end
            chk("flags", 40'h0, {36'h0, ovf_flags});
        end
        // Clock enable low freezes the accumulators
        @(posedge ref_clk);
        ce <= 1'h0;
        ld(2'h3, 32'h5);
        @(posedge ref_clk);
        ce <= 1'h1;
        @(negedge ref_clk);
        chk("acc3_ce", 40'hFF_7FFF_FFFF, acc3);
        // Mode register, byte enable, unmapped place
        bus(1'h1, OFS_CTRL, 32'h3, 4'hF);
        bus(1'h1, OFS_CTRL, 32'h0, 4'h0);
        bus(1'h1, 6'h3C, 32'hFFFF_FFFF, 4'hF);
        bus(1'h0, OFS_CTRL, 32'h0, 4'hF);
        chk("ctrl", 40'h3, {38'h0, rd[1:0]});
        chk("modes", 40'h3, {38'h0, sat_a, sat_d});
        bus(1'h0, 6'h3C, 32'h0, 4'hF);
        chk("unmapped", 40'h0, {8'h0, rd});
        // Guard bits absorb 256 and more products
        bus(1'h1, OFS_CTRL, 32'h0, 4'hF);
        mac(2'h0, 16'h8000, 16'h8000, 256);
        chk("acc0_256", 40'h40_0000_0000, acc0);
        chk("flags_256", 40'h0, {36'h0, ovf_flags});
        mac(2'h0, 16'h8000, 16'h8000, 255);
        chk("acc0_511", 40'h7F_C000_0000, acc0);
        mac(2'h0, 16'h8000, 16'h8000, 1);
        chk("acc0_wrap", 40'h80_0000_0000, acc0);
        chk("flag0", 40'h1, {36'h0, ovf_flags});
        ld(2'h0, 32'h0);
        chk("flag0_hold", 40'h1, {36'h0, ovf_flags});
        bus(1'h0, OFS_OVF, 32'h0, 4'hF);
        chk("ovf_reg", 40'h1, {36'h0, rd[3:0]});
        bus(1'h1, OFS_OVF, 32'h1, 4'hF);
        chk("flag0_clr", 40'h0, {36'h0, ovf_flags});
        // Data-unit clamp at both limits
        bus(1'h1, OFS_CTRL, 32'h1, 4'hF);
        ld(2'h2, 32'h8000_0000);
        mac(2'h2, 16'h8000, 16'h7FFF, 510);
        chk("acc2_510", 40'h80_00FF_0000, acc2);
        chk("flags_510", 40'h0, {36'h0, ovf_flags});
        mac(2'h2, 16'h8000, 16'h7FFF, 1);
        chk("acc2_sat", 40'h80_0000_0000, acc2);
        chk("flag2", 40'h4, {36'h0, ovf_flags});
        op_go('{1'h1, 1'h0, D_ADD, 2'h0, 32'h0, 16'h7FFF, 16'h1, 40'h0}, 1);
        chk("a_nosat", 40'h8000, {24'h0, a_result});
        ld(2'h1, 32'h0);
        chk("a_valid_lo", 40'h0, {39'h0, a_result_valid});
        mac(2'h1, 16'h8000, 16'h8000, 513);
        chk("acc1_sat", 40'h7F_FFFF_FFFF, acc1);
        chk("flag1", 40'h6, {36'h0, ovf_flags});
        bus(1'h0, 6'h18, 32'h0, 4'hF);
        chk("acc1_lo", 40'hFFFF_FFFF, {8'h0, rd});
        bus(1'h0, 6'h1C, 32'h0, 4'hF);
        chk("acc1_hi", 40'h7F, {8'h0, rd});
        // Reset in mid-run
        @(posedge ref_clk);
        rst_n <= 1'h0;
        @(posedge ref_clk);
        rst_n <= 1'h1;
        @(negedge ref_clk);
        chk("flags_rst2", 40'h0, {36'h0, ovf_flags});
        chk("acc1_rst2", 40'h0, acc1);
        chk("modes_rst2", 40'h0, {38'h0, sat_a, sat_d});
        chk("a_rst2", 40'h0, {24'h0, a_result});
        end_sim();
    end
endmodule
`default_nettype wire
